// *** pkg/pmr_cfg.svh ***
// Purpose: named constants of the power monitor result block
// Assumes: 250 MHz core clock
// Notes:   addresses are register pointer values
`ifndef PMR_CFG_SVH
`define PMR_CFG_SVH

// ----------------------------------------
// register pointer values
// ----------------------------------------
`define PMR_ADDR_VBUS    8'h05
`define PMR_ADDR_TEMP    8'h06
`define PMR_ADDR_CURRENT 8'h07
`define PMR_ADDR_POWER   8'h08
`define PMR_ADDR_ENERGY  8'h09
`define PMR_ADDR_CHARGE  8'h0A

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define PMR_ACC_W        40
`define PMR_POWER_W      24
`define PMR_TEMP_W       12
`define PMR_RES_RST      16'h0000
`define PMR_ACC_RST      40'h00_0000_0000
`define PMR_POWER_RST    24'h00_0000
`define PMR_POWER_SHIFT  6
`define PMR_POWER_MAX    24'hFF_FFFF

// ----------------------------------------
// conversion times in microseconds
// ----------------------------------------
`define PMR_CLK_MHZ      250
`define PMR_CT0_US       50
`define PMR_CT1_US       84
`define PMR_CT2_US       150
`define PMR_CT3_US       280
`define PMR_CT4_US       540
`define PMR_CT5_US       1052
`define PMR_CT6_US       2074
`define PMR_CT7_US       4120

// ----------------------------------------
// averaging counts as powers of two
// ----------------------------------------
`define PMR_AVG0_LOG2    4'h0
`define PMR_AVG1_LOG2    4'h2
`define PMR_AVG2_LOG2    4'h4
`define PMR_AVG3_LOG2    4'h6
`define PMR_AVG4_LOG2    4'h7
`define PMR_AVG5_LOG2    4'h8
`define PMR_AVG6_LOG2    4'h9
`define PMR_AVG7_LOG2    4'hA

`endif

// *** pkg/pmr_pkg.sv ***
// Purpose: shared types of the power monitor result block
// Assumes: nothing
// Notes:   constants live in pmr_cfg.svh
`default_nettype none
package pmr_pkg;
    typedef logic [7:0]  pmr_byte_t;
    typedef logic [2:0]  pmr_sel_t;
    typedef logic [39:0] pmr_acc_t;
endpackage : pmr_pkg
`default_nettype wire

// *** src/pmr_conv_timer.sv ***
// Purpose: conversion period timer, one tick per ADC conversion
// Assumes: ct_sel from same-clock logic
// Notes:   CYCLES_PER_US shortens periods in simulation
`include "pmr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pmr_conv_timer #(
    parameter int unsigned CYCLES_PER_US = `PMR_CLK_MHZ,
    parameter int          CNT_W         = 24
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // conversion time selection
    input  wire pmr_pkg::pmr_sel_t ct_sel,
    // tick and current period
    output logic                  tick,
    output logic [CNT_W-1:0]      period_cycles
);
    int unsigned             conv_us;
    logic        [CNT_W-1:0] cnt;

    // ----------------------------------------
    // period from selected conversion time
    // ----------------------------------------
    always_comb begin
        unique case (ct_sel)
            3'h0: conv_us = `PMR_CT0_US;
            3'h1: conv_us = `PMR_CT1_US;
            3'h2: conv_us = `PMR_CT2_US;
            3'h3: conv_us = `PMR_CT3_US;
            3'h4: conv_us = `PMR_CT4_US;
            3'h5: conv_us = `PMR_CT5_US;
            3'h6: conv_us = `PMR_CT6_US;
            3'h7: conv_us = `PMR_CT7_US;
        endcase
        period_cycles = CNT_W'(conv_us * CYCLES_PER_US);
        if (period_cycles == '0) begin
            period_cycles = CNT_W'(1);
        end
    end

    // free-running counter, wraps at the period
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (cnt >= period_cycles - CNT_W'(1));
            if (cnt >= period_cycles - CNT_W'(1)) begin
                cnt <= '0;
            end else begin
                cnt <= cnt + CNT_W'(1);
            end
        end
    end
endmodule : pmr_conv_timer
`default_nettype wire

// *** src/pmr_result_regs.sv ***
// Purpose: result registers and accumulators of a power monitor
// Assumes: ADC samples and read strobes come from same-clock logic
// Notes:   serial framing lives outside; this block sees bytes
//
// Summary of operation
// - current at 7h, 16-bit signed, 1.2 mA
// - bus voltage at 5h, never negative
// - temperature at 6h, 12-bit signed
// - power at 8h, 24-bit unsigned
// - energy 9h, charge Ah, 40-bit unsigned
// - signed fields in two's complement
// - temperature codes span -256 to +256 C
// - bus voltage codes reach 102.4 V
// - energy wraps to zero silently
// - accumulator clear zeroes energy and charge
// - charge overflow sets sticky flag
// - eight conversion times, 50 to 4120 us
// - averaging counts include 1, 4, 16
// - sample period is time times count
// - current full scale is 39.32 A
// - register bytes sent MSB first
// - pointer retained until rewritten
`include "pmr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pmr_result_regs #(
    parameter int unsigned CYCLES_PER_US = `PMR_CLK_MHZ,
    parameter int          CNT_W         = 24
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // configuration
    input  wire pmr_pkg::pmr_sel_t ct_sel,
    input  wire pmr_pkg::pmr_sel_t avg_sel,
    input  wire logic              accumulator_clear_bit,
    // raw conversion results
    input  wire logic [15:0]       adc_current,
    input  wire logic [15:0]       adc_vbus,
    input  wire logic [11:0]       adc_temp,
    // register pointer and read port
    input  wire logic              ptr_wr,
    input  wire pmr_pkg::pmr_byte_t ptr_byte,
    input  wire logic              rd_start,
    input  wire logic              rd_req,
    output pmr_pkg::pmr_byte_t     rd_byte,
    output logic                   rd_valid,
    // status
    output logic                   charge_overflow_flag,
    output logic                   sample_done
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic                  tick;
    logic [CNT_W-1:0]      period_cycles;
    logic [3:0]            avg_log2;
    logic [9:0]            avg_cnt;
    logic [9:0]            avg_last;
    logic signed [25:0]    sum_cur;
    logic signed [25:0]    sum_vb;
    logic signed [21:0]    sum_tmp;
    logic signed [25:0]    next_sum_cur;
    logic signed [25:0]    next_sum_vb;
    logic signed [21:0]    next_sum_tmp;
    logic signed [25:0]    avg_cur;
    logic signed [25:0]    avg_vb;
    logic signed [21:0]    avg_tmp;
    logic                  last_conv;
    logic [15:0]           current_result;
    logic [15:0]           bus_voltage_result;
    logic [11:0]           die_temperature_result;
    logic [23:0]           power_result;
    pmr_pkg::pmr_acc_t     energy_accumulator;
    pmr_pkg::pmr_acc_t     charge_accumulator;
    logic [15:0]           next_cur;
    logic [15:0]           next_vb;
    logic [15:0]           cur_mag;
    logic [31:0]           prod;
    logic [25:0]           prod_scaled;
    logic [23:0]           next_power;
    logic [40:0]           charge_sum;
    pmr_pkg::pmr_byte_t    ptr;
    pmr_pkg::pmr_acc_t     rd_aligned;
    pmr_pkg::pmr_acc_t     rd_snap;
    logic                  rd_first;

    // conversion period timer
    pmr_conv_timer #(
        .CYCLES_PER_US (CYCLES_PER_US),
        .CNT_W         (CNT_W)
    ) u_timer (
        .clock         (clock),
        .rst           (rst),
        .ct_sel        (ct_sel),
        .tick          (tick),
        .period_cycles (period_cycles)
    );

    // ----------------------------------------
    // averaging
    // ----------------------------------------
    // averaging count as a shift amount
    always_comb begin
        unique case (avg_sel)
            3'h0: avg_log2 = `PMR_AVG0_LOG2;
            3'h1: avg_log2 = `PMR_AVG1_LOG2;
            3'h2: avg_log2 = `PMR_AVG2_LOG2;
            3'h3: avg_log2 = `PMR_AVG3_LOG2;
            3'h4: avg_log2 = `PMR_AVG4_LOG2;
            3'h5: avg_log2 = `PMR_AVG5_LOG2;
            3'h6: avg_log2 = `PMR_AVG6_LOG2;
            3'h7: avg_log2 = `PMR_AVG7_LOG2;
        endcase
        avg_last = 10'((11'h001 << avg_log2) - 11'h001);
    end

    // running sums including this conversion
    always_comb begin
        next_sum_cur = sum_cur + 26'(signed'(adc_current));
        next_sum_vb  = sum_vb + 26'(signed'(adc_vbus));
        next_sum_tmp = sum_tmp + 22'(signed'(adc_temp));
        avg_cur      = next_sum_cur >>> avg_log2;
        avg_vb       = next_sum_vb >>> avg_log2;
        avg_tmp      = next_sum_tmp >>> avg_log2;
        last_conv    = tick && (avg_cnt >= avg_last);
    end

    // conversion counter and sums
    always_ff @(posedge clock) begin
        if (rst) begin
            avg_cnt <= 10'h000;
            sum_cur <= 26'sh000_0000;
            sum_vb  <= 26'sh000_0000;
            sum_tmp <= 22'sh00_0000;
        end else if (last_conv) begin
            avg_cnt <= 10'h000;
            sum_cur <= 26'sh000_0000;
            sum_vb  <= 26'sh000_0000;
            sum_tmp <= 22'sh00_0000;
        end else if (tick) begin
            avg_cnt <= avg_cnt + 10'h001;
            sum_cur <= next_sum_cur;
            sum_vb  <= next_sum_vb;
            sum_tmp <= next_sum_tmp;
        end
    end

    // ----------------------------------------
    // measurement results
    // ----------------------------------------
    // averaged values, bus voltage clamped at zero
    always_comb begin
        next_cur = avg_cur[15:0];
        next_vb  = avg_vb[15] ? `PMR_RES_RST : avg_vb[15:0];
    end

    // result registers load once per output sample
    always_ff @(posedge clock) begin
        if (rst) begin
            current_result         <= `PMR_RES_RST;
            bus_voltage_result     <= `PMR_RES_RST;
            die_temperature_result <= `PMR_TEMP_W'(`PMR_RES_RST);
            sample_done            <= 1'b0;
        end else begin
            sample_done <= last_conv;
            if (last_conv) begin
                current_result         <= next_cur;
                bus_voltage_result     <= next_vb;
                die_temperature_result <= avg_tmp[11:0];
            end
        end
    end

    // power from averaged current magnitude and bus voltage
    always_comb begin
        cur_mag     = next_cur[15] ? 16'(-next_cur) : next_cur;
        prod        = cur_mag * next_vb;
        prod_scaled = prod[31:`PMR_POWER_SHIFT];
        next_power  = (prod_scaled[25:24] != 2'h0) ? `PMR_POWER_MAX : prod_scaled[23:0];
        charge_sum  = {1'b0, charge_accumulator} + 41'(cur_mag);
    end

    // power register
    always_ff @(posedge clock) begin
        if (rst) begin
            power_result <= `PMR_POWER_RST;
        end else if (last_conv) begin
            power_result <= next_power;
        end
    end

    // ----------------------------------------
    // energy and charge accumulators
    // ----------------------------------------
    // energy wraps silently; clear wins over an addition
    always_ff @(posedge clock) begin
        if (rst) begin
            energy_accumulator <= `PMR_ACC_RST;
        end else if (accumulator_clear_bit) begin
            energy_accumulator <= `PMR_ACC_RST;
        end else if (last_conv) begin
            energy_accumulator <= energy_accumulator + `PMR_ACC_W'(next_power);
        end
    end

    // charge keeps wrapping until software clears it
    always_ff @(posedge clock) begin
        if (rst) begin
            charge_accumulator <= `PMR_ACC_RST;
        end else if (accumulator_clear_bit) begin
            charge_accumulator <= `PMR_ACC_RST;
        end else if (last_conv) begin
            charge_accumulator <= charge_sum[39:0];
        end
    end

    // sticky overflow flag, a new overflow beats the clear
    always_ff @(posedge clock) begin
        if (rst) begin
            charge_overflow_flag <= 1'b0;
        end else if (last_conv && charge_sum[40]) begin
            charge_overflow_flag <= 1'b1;
        end else if (accumulator_clear_bit) begin
            charge_overflow_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // register pointer and byte read
    // ----------------------------------------
    // pointer changes only on a pointer write
    always_ff @(posedge clock) begin
        if (rst) begin
            ptr <= 8'h00;
        end else if (ptr_wr) begin
            ptr <= ptr_byte;
        end
    end

    // selected register, left justified for MSB-first shifting
    always_comb begin
        unique case (ptr)
            `PMR_ADDR_VBUS:    rd_aligned = {bus_voltage_result, 24'h00_0000};
            `PMR_ADDR_TEMP:    rd_aligned = {4'h0, die_temperature_result, 24'h00_0000};
            `PMR_ADDR_CURRENT: rd_aligned = {current_result, 24'h00_0000};
            `PMR_ADDR_POWER:   rd_aligned = {power_result, 16'h0000};
            `PMR_ADDR_ENERGY:  rd_aligned = energy_accumulator;
            `PMR_ADDR_CHARGE:  rd_aligned = charge_accumulator;
            default:           rd_aligned = `PMR_ACC_RST;
        endcase
    end

    // first byte snapshots the register, later bytes shift out
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_first <= 1'b1;
            rd_snap  <= `PMR_ACC_RST;
            rd_byte  <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_req;
            if (rd_start || ptr_wr) begin
                rd_first <= 1'b1;
            end else if (rd_req) begin
                rd_first <= 1'b0;
                if (rd_first) begin
                    rd_byte <= rd_aligned[39:32];
                    rd_snap <= {rd_aligned[31:0], 8'h00};
                end else begin
                    rd_byte <= rd_snap[39:32];
                    rd_snap <= {rd_snap[31:0], 8'h00};
                end
            end
        end
    end

    // ----------------------------------------
    // assertion helpers
    // ----------------------------------------
    logic [31:0] gap_cnt;
    logic        gap_valid;
    logic [31:0] gap_expect;

    always_comb begin
        gap_expect = (32'(period_cycles) << avg_log2) - 32'h0000_0001;
    end

    // cycles between output samples under steady settings
    always_ff @(posedge clock) begin
        if (rst) begin
            gap_cnt   <= 32'h0000_0000;
            gap_valid <= 1'b0;
        end else begin
            gap_cnt <= sample_done ? 32'h0000_0000 : gap_cnt + 32'h0000_0001;
            if ($changed(ct_sel) || $changed(avg_sel)) begin
                gap_valid <= 1'b0;
            end else if (sample_done) begin
                gap_valid <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_ptr_retained: assert property (@(posedge clock) disable iff (rst)
        !ptr_wr |=> ptr == $past(ptr))
        else $error("register pointer changed without a write");

    a_vbus_nonneg: assert property (@(posedge clock) disable iff (rst)
        bus_voltage_result[15] == 1'b0)
        else $error("bus voltage result went negative");

    a_temp_upper_zero: assert property (@(posedge clock) disable iff (rst)
        ptr == `PMR_ADDR_TEMP && rd_req && rd_first |=> rd_byte[7:4] == 4'h0)
        else $error("temperature upper bits not zero");

    a_clear_accs: assert property (@(posedge clock) disable iff (rst)
        accumulator_clear_bit |=> energy_accumulator == `PMR_ACC_RST
                                  && charge_accumulator == `PMR_ACC_RST)
        else $error("accumulators not cleared");

    a_ovf_flag_set: assert property (@(posedge clock) disable iff (rst)
        last_conv && charge_sum[40] |=> charge_overflow_flag ##1 charge_overflow_flag
                                        || $past(accumulator_clear_bit))
        else $error("charge overflow flag not set");

    a_energy_wrap: assert property (@(posedge clock) disable iff (rst)
        sample_done && !$past(accumulator_clear_bit) |->
            energy_accumulator == `PMR_ACC_W'($past(energy_accumulator)
                                 + `PMR_ACC_W'(power_result)))
        else $error("energy did not add the new power");

    a_current_single: assert property (@(posedge clock) disable iff (rst)
        last_conv && avg_sel == 3'h0 |=> current_result == $past(adc_current))
        else $error("current result not the single conversion");

    a_msb_first: assert property (@(posedge clock) disable iff (rst)
        rd_req && rd_first && !rd_start && !ptr_wr && ptr == `PMR_ADDR_CURRENT
        ##1 rd_req && !rd_start && !ptr_wr
        |-> rd_byte == $past(current_result[15:8]) ##1 rd_byte == $past(current_result[7:0], 2))
        else $error("register bytes not most significant first");

    a_sample_period: assert property (@(posedge clock) disable iff (rst)
        sample_done && gap_valid && $stable(ct_sel) && $stable(avg_sel) |->
            gap_cnt == gap_expect)
        else $error("output sample period wrong");

    a_flag_holds: assert property (@(posedge clock) disable iff (rst)
        charge_overflow_flag && !accumulator_clear_bit |=> charge_overflow_flag)
        else $error("overflow flag dropped on its own");

    // ----------------------------------------
    // cover properties
    // ----------------------------------------
    c_sample: cover property (@(posedge clock) disable iff (rst) sample_done);
    c_overflow: cover property (@(posedge clock) disable iff (rst)
        $rose(charge_overflow_flag));
    c_energy_read: cover property (@(posedge clock) disable iff (rst)
        ptr == `PMR_ADDR_ENERGY && rd_req ##1 rd_req ##1 rd_req ##1 rd_req ##1 rd_req);
    c_clear: cover property (@(posedge clock) disable iff (rst)
        accumulator_clear_bit && charge_overflow_flag);
endmodule : pmr_result_regs
`default_nettype wire

// *** tb/pmr_reader_model.sv ***
// Purpose: bus controller model reading the result registers
// Assumes: pointer and byte strobes of pmr_result_regs
// Notes:   drives on the falling edge; gap makes a slow reader
`timescale 1ns/1ps
`default_nettype none
module pmr_reader_model (
    // clock
    input  wire logic               clock,
    // read port of the block
    input  wire pmr_pkg::pmr_byte_t rd_byte,
    input  wire logic               rd_valid,
    output logic                    ptr_wr,
    output pmr_pkg::pmr_byte_t      ptr_byte,
    output logic                    rd_start,
    output logic                    rd_req
);
    // idle bus at time zero
    initial begin
        ptr_wr   = 1'b0;
        ptr_byte = 8'h00;
        rd_start = 1'b0;
        rd_req   = 1'b0;
    end

    // raw code times step weight gives physical units
    function automatic real scaled(input real raw, input real lsb);
        return raw * lsb;
    endfunction : scaled

    // one register read, bytes gathered msb first
    task automatic read_reg(input logic set_ptr, input logic [7:0] addr, input int nbytes,
                            input int gap, output logic [39:0] value, output logic ok);
        int k;
        value = 40'h00_0000_0000;
        ok    = 1'b1;
        @(negedge clock);
        if (set_ptr) begin
            ptr_wr   = 1'b1;
            ptr_byte = addr;
            @(negedge clock);
            ptr_wr   = 1'b0;
            ptr_byte = ~addr; // stale pointer byte shown inverted
        end
        rd_start = 1'b1;
        @(negedge clock);
        rd_start = 1'b0;
        for (int b = 0; b < nbytes; b++) begin
            repeat (gap) @(negedge clock);
            rd_req = 1'b1;
            @(negedge clock);
            // back-to-back bytes keep the request up, no zero-width dip
            if (gap > 0 || b == nbytes - 1) rd_req = 1'b0;
            k = 0;
            while (rd_valid !== 1'b1 && k < 4) begin
                @(negedge clock);
                k++;
            end
            if (rd_valid !== 1'b1) ok = 1'b0;
            value = {value[31:0], rd_byte};
        end
    endtask : read_reg
endmodule : pmr_reader_model
`default_nettype wire

// *** tb/pmr_result_regs_test.sv ***
// Purpose: self-checking bench of the power monitor result block
// Assumes: CYCLES_PER_US of 1, one cycle per microsecond
// Notes:   a bench model follows every output sample
`timescale 1ns/1ps
`default_nettype none
module pmr_result_regs_test;
    logic               clock;
    logic               rst;
    pmr_pkg::pmr_sel_t  ct_sel;
    pmr_pkg::pmr_sel_t  avg_sel;
    logic               accumulator_clear_bit;
    logic [15:0]        adc_current;
    logic [15:0]        adc_vbus;
    logic [11:0]        adc_temp;
    logic               ptr_wr;
    pmr_pkg::pmr_byte_t ptr_byte;
    logic               rd_start;
    logic               rd_req;
    pmr_pkg::pmr_byte_t rd_byte;
    logic               rd_valid;
    logic               charge_overflow_flag;
    logic               sample_done;
    logic [39:0]        e_cur, e_vbus, e_temp, e_power, e_energy, e_charge;
    longint             mag, pw;
    logic [31:0]        rnd;
    int                 n_errors, n_compared;
    int                 ct_us[8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};

    // 4 ns clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    pmr_result_regs #(.CYCLES_PER_US(1), .CNT_W(24)) pmr_result_regs_inst (
        .clock(clock), .rst(rst), .ct_sel(ct_sel), .avg_sel(avg_sel),
        .accumulator_clear_bit(accumulator_clear_bit), .adc_current(adc_current),
        .adc_vbus(adc_vbus), .adc_temp(adc_temp), .ptr_wr(ptr_wr), .ptr_byte(ptr_byte),
        .rd_start(rd_start), .rd_req(rd_req), .rd_byte(rd_byte), .rd_valid(rd_valid),
        .charge_overflow_flag(charge_overflow_flag), .sample_done(sample_done));

    pmr_reader_model pmr_reader_model_inst (
        .clock(clock), .rd_byte(rd_byte), .rd_valid(rd_valid), .ptr_wr(ptr_wr),
        .ptr_byte(ptr_byte), .rd_start(rd_start), .rd_req(rd_req));

    // ----------------------------------------
    // bench model of results and accumulators
    // ----------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            {e_cur, e_vbus, e_temp, e_power, e_energy, e_charge} = '0;
        end else begin
            if (sample_done === 1'b1) begin
                mag = adc_current[15] ? 65536 - longint'(adc_current) : longint'(adc_current);
                pw  = (mag * (adc_vbus[15] ? 0 : longint'(adc_vbus))) >>> 6;
                if (pw > 64'hFF_FFFF) pw = 64'hFF_FFFF;
                e_cur    = 40'(adc_current);
                e_vbus   = adc_vbus[15] ? 40'h00_0000_0000 : 40'(adc_vbus);
                e_temp   = 40'(adc_temp);
                e_power  = 40'(pw);
                e_energy = e_energy + 40'(pw);
                e_charge = e_charge + 40'(mag);
            end
            if (accumulator_clear_bit) begin
                e_energy = '0;
                e_charge = '0;
            end
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
    endfunction : lfsr_next

    task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    // counts cycles up to the next sample pulse
    task automatic wait_sample(output int cyc);
        cyc = 0;
        do begin
            @(negedge clock);
            cyc++;
        end while (sample_done !== 1'b1 && cyc < 20000);
        if (sample_done !== 1'b1) begin
            n_errors++;
            complete_run();
        end
    endtask : wait_sample

    task automatic read_check(input logic set_ptr, input logic [7:0] addr, input int nb,
                              input logic [39:0] exp, input string name);
        logic [39:0] val;
        logic        ok;
        rnd = lfsr_next(rnd);
        pmr_reader_model_inst.read_reg(set_ptr, addr, nb, int'(rnd[1:0]), val, ok);
        check("read answered", 40'(ok), 40'h00_0000_0001);
        check(name, val, exp);
    endtask : read_check

    task automatic set_adc(input logic [15:0] i, input logic [15:0] v, input logic [11:0] t);
        @(negedge clock);
        adc_current = i;
        adc_vbus    = v;
        adc_temp    = t;
    endtask : set_adc

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int cyc;
        rnd = 32'd89851;
        n_errors = 0;
        n_compared = 0;
        rst = 1'b1;
        ct_sel = 3'h0;
        avg_sel = 3'h0;
        accumulator_clear_bit = 1'b0;
        adc_current = 16'h0000;
        adc_vbus = 16'h0000;
        adc_temp = 12'h000;
        repeat (20) @(negedge clock);
        rst = 1'b0;
        read_check(1'b1, 8'h07, 2, 40'h00_0000_0000, "current after reset");
        read_check(1'b1, 8'h0A, 5, 40'h00_0000_0000, "charge after reset");
        $display("test reset done");
        // every conversion time, single sample
        for (int c = 0; c < 8; c++) begin
            @(negedge clock);
            ct_sel = 3'(c);
            repeat (3) wait_sample(cyc);
            check("sample period", 40'(cyc), 40'(ct_us[c]));
        end
        // averaging by 4, 16 and 64 at 150 us
        @(negedge clock);
        ct_sel = 3'h2;
        for (int a = 1; a < 4; a++) begin
            @(negedge clock);
            avg_sel = 3'(a);
            repeat (3) wait_sample(cyc);
            check("averaged period", 40'(cyc), 40'(150 << (2 * a)));
        end
        $display("test periods done");
        // values of every register after random samples
        @(negedge clock);
        ct_sel = 3'h3;
        avg_sel = 3'h0;
        wait_sample(cyc);
        accumulator_clear_bit = 1'b1;
        @(negedge clock);
        accumulator_clear_bit = 1'b0;
        for (int n = 0; n < 6; n++) begin
            rnd = lfsr_next(rnd);
            if (n == 0) set_adc(16'h8000, 16'hFFFF, 12'h800); // extreme codes
            else set_adc(rnd[15:0], rnd[31:16], rnd[27:16]);
            wait_sample(cyc);
            @(negedge clock); // bench model takes the pulse one edge later
            read_check(1'b1, 8'h07, 3, {e_cur[31:0], 8'h00}, "current");
            read_check(1'b0, 8'h07, 2, e_cur, "current again");
            read_check(1'b1, 8'h05, 2, e_vbus, "bus voltage");
            read_check(1'b1, 8'h06, 2, e_temp, "temperature");
            read_check(1'b1, 8'h08, 3, e_power, "power");
            read_check(1'b1, 8'h09, 5, e_energy, "energy");
            read_check(1'b1, 8'h0A, 5, e_charge, "charge");
            read_check(1'b1, 8'h0B, 2, 40'h00_0000_0000, "unmapped");
            check("overflow flag", 40'(charge_overflow_flag), 40'h00_0000_0000);
        end
        $display("test values done");
        // software restarts both accumulators
        wait_sample(cyc);
        accumulator_clear_bit = 1'b1;
        @(negedge clock);
        accumulator_clear_bit = 1'b0;
        read_check(1'b1, 8'h09, 5, 40'h00_0000_0000, "energy cleared");
        read_check(1'b1, 8'h0A, 5, 40'h00_0000_0000, "charge cleared");
        $display("test clear done");
        complete_run();
    end
endmodule : pmr_result_regs_test
`default_nettype wire
